// ===== verilog/afp_cfg.svh
// Constants for the converter output format and power mode block
// Function
// [RULE_01] Sample on rising edge; stabilizer makes falling edge
// [RULE_02] Stabilizer accepts 40-60% duty, gives 50%
// [RULE_03] About hundred clocks relock after clock stop
// [RULE_04] Source keeps duty 45-55% without stabilizer
// [RULE_05] Offset binary: zeros, one-then-zeros, all ones
// [RULE_06] Twos complement: offset binary, top bit inverted
// [RULE_07] Out of range raises flag, word saturates
// [RULE_08] Four-level input selects format and stabilizer
// [RULE_09] Disable input floats data and flag
// [RULE_10] Do not toggle disable while sampling fast
// [RULE_11] Power-down low means normal conversion
// [RULE_12] Power-down plus disable: sleep, millisecond recovery
// [RULE_13] Power-down alone: nap, 100 clock recovery
// [RULE_14] Sleep and nap float every output; only the data word and flag float here, strobe is held low
// [RULE_15] Fast rate change: stabilizer off, no relock
// [RULE_16] Source keeps rate at least 1 Msps
// [RULE_17] Flag invalid samples during relock and recovery
`ifndef AFP_CFG_SVH
`define AFP_CFG_SVH

`define AFP_WORD_W 14
`define AFP_IN_W 16
`define AFP_CNT_W 20
`define AFP_POS_FS 16'sh1fff
`define AFP_NEG_FS (-16'sh2000)
`define AFP_MSB 13
`define AFP_CLK_PERIOD_NS 10
`define AFP_STOP_NS 1000
`define AFP_STOP_CYC ((`AFP_STOP_NS + `AFP_CLK_PERIOD_NS - 1) / `AFP_CLK_PERIOD_NS)
`define AFP_RELOCK_CLKS 100
`define AFP_NAP_CLKS 100
`define AFP_SLEEP_NS 1000000
`define AFP_SLEEP_CYC ((`AFP_SLEEP_NS + `AFP_CLK_PERIOD_NS - 1) / `AFP_CLK_PERIOD_NS)
`define AFP_DUTY_STAB_LO 40
`define AFP_DUTY_STAB_HI 60
`define AFP_DUTY_RAW_LO 45
`define AFP_DUTY_RAW_HI 55
`define AFP_PCT 100
`define AFP_RATE_SHIFT 3

`endif

// ===== verilog/afp_pkg.sv
// Types shared by the converter output format and power mode block
package afp_pkg;
	typedef enum logic [2:0] {
		AFP_RUN = 3'h0,
		AFP_NAP = 3'h1,
		AFP_SLEEP = 3'h2,
		AFP_NAP_RCV = 3'h3,
		AFP_SLEEP_RCV = 3'h4
	} afp_pwr_e;

	typedef struct packed {
		logic twos;
		logic stab_on;
	} afp_mode_s;

	typedef struct packed {
		logic [13:0] word;
		logic over;
	} afp_sample_s;
endpackage

// ===== verilog/afp_top.sv
// Output formatting, clock stabilizer and power state control of the converter
`timescale 1ns/1ps
`include "afp_cfg.svh"

module afp_top #(
	parameter int SLEEP_CYC = `AFP_SLEEP_CYC
) (
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire logic sample_clk_in,
	input wire logic [1:0] mode_level_in,
	input wire logic power_down_select_in,
	input wire logic out_disable_in,
	input wire logic signed [15:0] analog_value_in,
	output logic [13:0] sample_word_out,
	output logic sample_word_oe_out,
	output logic range_exceeded_flag_out,
	output logic range_exceeded_flag_oe_out,
	output logic sample_strobe_out,
	output logic data_invalid_out,
	output logic stab_locked_out,
	output logic internal_clk_out,
	output logic duty_fault_out,
	output afp_pkg::afp_mode_s mode_out,
	output afp_pkg::afp_pwr_e power_state_out
);
	import afp_pkg::*;

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	function automatic afp_sample_s convert(input logic signed [15:0] v,
		input logic twos);
		afp_sample_s s;
		logic signed [15:0] c;
		c = v;
		s.over = 1'b0;
		if (v > `AFP_POS_FS) begin
			c = `AFP_POS_FS; // RULE_07
			s.over = 1'b1;
		end else if (v < `AFP_NEG_FS) begin
			c = `AFP_NEG_FS; // RULE_07
			s.over = 1'b1;
		end
		s.word = c[13:0];
		s.word[`AFP_MSB] = ~c[`AFP_MSB]; // RULE_05
		if (twos) begin
			s.word[`AFP_MSB] = ~s.word[`AFP_MSB]; // RULE_06
		end
		return s;
	endfunction

	function automatic logic duty_ok(input logic [19:0] high,
		input logic [19:0] period, input logic [6:0] lo, input logic [6:0] hi);
		logic [27:0] h;
		logic [27:0] p;
		h = 28'(high) * 28'(`AFP_PCT);
		p = 28'(period);
		return (h >= p * 28'(lo)) && (h <= p * 28'(hi));
	endfunction

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic clk_meta;
	logic clk_sync;
	logic clk_prev;
	logic [1:0] mode_meta;
	logic [1:0] mode_sync;
	logic pd_meta;
	logic pd_sync;
	logic dis_meta;
	logic dis_sync;

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			clk_meta <= 1'b0;
			clk_sync <= 1'b0;
			clk_prev <= 1'b0;
			mode_meta <= 2'h0;
			mode_sync <= 2'h0;
			pd_meta <= 1'b0;
			pd_sync <= 1'b0;
			dis_meta <= 1'b0;
			dis_sync <= 1'b0;
		end else begin
			clk_meta <= sample_clk_in;
			clk_sync <= clk_meta;
			clk_prev <= clk_sync;
			mode_meta <= mode_level_in;
			mode_sync <= mode_meta;
			pd_meta <= power_down_select_in;
			pd_sync <= pd_meta;
			dis_meta <= out_disable_in;
			dis_sync <= dis_meta;
		end
	end

	logic clk_rise;
	logic clk_fall;
	assign clk_rise = clk_sync & ~clk_prev; // RULE_01
	assign clk_fall = ~clk_sync & clk_prev;

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	afp_mode_s mode;
	always_comb begin
		mode.twos = mode_sync[1]; // RULE_08
		mode.stab_on = mode_sync[1] ^ mode_sync[0]; // RULE_08
	end

	// ------------------------------------------------------------
	// Sample clock period and high time
	// ------------------------------------------------------------
	logic [19:0] run_cnt;
	logic [19:0] period;
	logic [19:0] high_time;
	logic clk_stopped;

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			run_cnt <= 20'h0;
			period <= 20'h0;
			high_time <= 20'h0;
			clk_stopped <= 1'b1;
		end else if (clk_rise) begin
			run_cnt <= 20'h1;
			period <= run_cnt;
			clk_stopped <= 1'b0;
		end else begin
			if (run_cnt < 20'(`AFP_STOP_CYC)) begin
				run_cnt <= run_cnt + 20'h1;
			end else begin
				clk_stopped <= 1'b1; // RULE_03
			end
			if (clk_fall) begin
				high_time <= run_cnt;
			end
		end
	end

	// Large jump in period means the source changed rate
	logic rate_jump;
	logic [19:0] delta;
	always_comb begin
		delta = (run_cnt > period) ? run_cnt - period : period - run_cnt;
		rate_jump = (period != 20'h0) && (delta > (period >> `AFP_RATE_SHIFT));
	end

	// ------------------------------------------------------------
	// Stabilizer lock tracking
	// ------------------------------------------------------------
	logic stab_prev;
	logic [6:0] lock_cnt;
	logic locked;

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			stab_prev <= 1'b0;
			lock_cnt <= 7'h0;
			locked <= 1'b0;
		end else begin
			stab_prev <= mode.stab_on;
			if (clk_stopped || (mode.stab_on && !stab_prev)) begin
				lock_cnt <= 7'h0; // RULE_03
				locked <= 1'b0;
			end else if (clk_rise && mode.stab_on && rate_jump) begin
				lock_cnt <= 7'h0; // RULE_15
				locked <= 1'b0;
			end else if (clk_rise && !locked) begin
				if (lock_cnt == 7'(`AFP_RELOCK_CLKS - 1)) begin
					locked <= 1'b1; // RULE_03
				end else begin
					lock_cnt <= lock_cnt + 7'h1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Internal clock regeneration
	// ------------------------------------------------------------
	// External falling edge is not used while the stabilizer runs
	logic int_clk;
	logic [19:0] half_cnt;

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			int_clk <= 1'b0;
			half_cnt <= 20'h0;
		end else if (!mode.stab_on) begin
			int_clk <= clk_sync; // RULE_15
			half_cnt <= 20'h0;
		end else if (clk_rise) begin
			int_clk <= 1'b1; // RULE_01
			half_cnt <= 20'h1;
		end else if (int_clk) begin
			half_cnt <= half_cnt + 20'h1;
			if (half_cnt >= (period >> 1)) begin
				int_clk <= 1'b0; // RULE_02
			end
		end
	end

	// ------------------------------------------------------------
	// Duty cycle check
	// ------------------------------------------------------------
	logic duty_fault;
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			duty_fault <= 1'b0;
		end else if (clk_rise && period != 20'h0) begin
			if (mode.stab_on) begin
				duty_fault <= !duty_ok(high_time, period,
					7'(`AFP_DUTY_STAB_LO), 7'(`AFP_DUTY_STAB_HI)); // RULE_02
			end else begin
				duty_fault <= !duty_ok(high_time, period,
					7'(`AFP_DUTY_RAW_LO), 7'(`AFP_DUTY_RAW_HI)); // RULE_04
			end
		end
	end

	// ------------------------------------------------------------
	// Power state machine
	// ------------------------------------------------------------
	afp_pwr_e pwr;
	afp_pwr_e next_pwr;
	logic [19:0] rcv_cnt;

	always_comb begin
		next_pwr = pwr;
		case (pwr)
			AFP_RUN: begin
				if (pd_sync) begin
					next_pwr = dis_sync ? AFP_SLEEP : AFP_NAP; // RULE_12 RULE_13
				end
			end
			AFP_NAP, AFP_NAP_RCV: begin
				if (pd_sync) begin
					next_pwr = dis_sync ? AFP_SLEEP : AFP_NAP;
				end else if (pwr == AFP_NAP) begin
					next_pwr = AFP_NAP_RCV;
				end else if (clk_rise && rcv_cnt == 20'(`AFP_NAP_CLKS - 1)) begin
					next_pwr = AFP_RUN; // RULE_13
				end
			end
			AFP_SLEEP, AFP_SLEEP_RCV: begin
				if (pd_sync) begin
					next_pwr = AFP_SLEEP;
				end else if (pwr == AFP_SLEEP) begin
					next_pwr = AFP_SLEEP_RCV;
				end else if (rcv_cnt == 20'(SLEEP_CYC - 1)) begin
					next_pwr = AFP_RUN; // RULE_12
				end
			end
			default: begin
				next_pwr = AFP_RUN;
			end
		endcase
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			pwr <= AFP_RUN;
		end else begin
			pwr <= next_pwr;
		end
	end

	// Nap recovery counts sample clocks, sleep counts reference time
	always_ff @(posedge ref_clk_in) begin
		if (reset_in || next_pwr != pwr) begin
			rcv_cnt <= 20'h0;
		end else if (pwr == AFP_SLEEP_RCV) begin
			rcv_cnt <= rcv_cnt + 20'h1;
		end else if (pwr == AFP_NAP_RCV && clk_rise) begin
			rcv_cnt <= rcv_cnt + 20'h1;
		end
	end

	// ------------------------------------------------------------
	// Conversion and outputs
	// ------------------------------------------------------------
	logic powered;
	logic invalid;
	afp_sample_s conv;
	assign powered = (pwr != AFP_NAP) && (pwr != AFP_SLEEP);
	assign invalid = !powered || pwr != AFP_RUN || (mode.stab_on && !locked);
	assign conv = convert(analog_value_in, mode.twos);

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			sample_word_out <= 14'h0;
			range_exceeded_flag_out <= 1'b0;
			sample_strobe_out <= 1'b0;
		end else begin
			sample_strobe_out <= clk_rise && powered; // RULE_11
			if (clk_rise && powered) begin
				sample_word_out <= conv.word; // RULE_01
				range_exceeded_flag_out <= conv.over; // RULE_07
			end
		end
	end

	// Release and enable are slow in silicon; callers keep it static
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			sample_word_oe_out <= 1'b0;
			range_exceeded_flag_oe_out <= 1'b0;
		end else begin
			sample_word_oe_out <= !dis_sync && powered; // RULE_09 RULE_14
			range_exceeded_flag_oe_out <= !dis_sync && powered; // RULE_09 RULE_14
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			data_invalid_out <= 1'b1;
			stab_locked_out <= 1'b0;
			internal_clk_out <= 1'b0;
			duty_fault_out <= 1'b0;
			mode_out <= '0;
			power_state_out <= AFP_RUN;
		end else begin
			data_invalid_out <= invalid; // RULE_17
			stab_locked_out <= locked;
			internal_clk_out <= int_clk;
			duty_fault_out <= duty_fault;
			mode_out <= mode;
			power_state_out <= pwr;
		end
	end
endmodule

// ===== dv/afp_chk.sv
// Port assertions for the converter format and power block
`timescale 1ns/1ps
module afp_chk
	import afp_pkg::*;
#(
	parameter int SLEEP_CYC = 50
) (
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire logic [1:0] mode_level_in,
	input wire logic [13:0] sample_word_out,
	input wire logic sample_word_oe_out,
	input wire logic range_exceeded_flag_out,
	input wire logic range_exceeded_flag_oe_out,
	input wire logic sample_strobe_out,
	input wire logic data_invalid_out,
	input wire afp_mode_s mode_out,
	input wire afp_pwr_e power_state_out
);
	logic off_st;
	logic rcv_st;
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (reset_in);
	assign off_st = power_state_out inside {AFP_NAP, AFP_SLEEP};
	assign rcv_st = power_state_out inside {AFP_NAP_RCV, AFP_SLEEP_RCV};
	AST_OE_PAIR: assert property (range_exceeded_flag_oe_out == sample_word_oe_out)
		else $error("enables differ");
	AST_STROBE_ONE: assert property (sample_strobe_out |=> !sample_strobe_out)
		else $error("strobe too long");
	AST_OFF_FLOAT: assert property (off_st |-> !sample_word_oe_out &&
		!range_exceeded_flag_oe_out && !sample_strobe_out) else $error("driven while off");
	AST_OB_SAT: assert property (sample_strobe_out && range_exceeded_flag_out &&
		!mode_out.twos |-> sample_word_out inside {14'h0, 14'h3fff}) else $error("ob sat");
	AST_TC_SAT: assert property (sample_strobe_out && range_exceeded_flag_out &&
		mode_out.twos |-> sample_word_out inside {14'h2000, 14'h1fff}) else $error("tc sat");
	AST_WORD_HOLD: assert property (!sample_strobe_out |->
		$stable(sample_word_out) && $stable(range_exceeded_flag_out)) else $error("word moved");
	AST_RCV_INVALID: assert property (rcv_st ##1 rcv_st |-> data_invalid_out)
		else $error("valid in recovery");
	AST_MODE_MAP: assert property ($stable(mode_level_in)[*6] |->
		mode_out == {mode_level_in[1], ^mode_level_in}) else $error("mode decode");
	cover property (sample_strobe_out && range_exceeded_flag_out);
	cover property (power_state_out == AFP_NAP_RCV ##1 power_state_out == AFP_RUN);
	cover property (power_state_out == AFP_SLEEP_RCV ##1 power_state_out == AFP_RUN);
endmodule

bind afp_top afp_chk #(.SLEEP_CYC(SLEEP_CYC)) chk_u (.*);

// ===== dv/afp_sink.sv
// Downstream capture logic reading the sample pins
`timescale 1ns/1ps
module afp_sink (
	input wire logic clk_in,
	input wire logic [13:0] word_in,
	input wire logic word_oe_in,
	input wire logic flag_in,
	input wire logic flag_oe_in,
	input wire logic strobe_in,
	output logic [14:0] got_out
);
	logic [14:0] held = 15'h0;
	logic [14:0] pin;
	// Floating pins wander each cycle, so stale data never reads as valid
	always_comb begin
		pin[13:0] = word_oe_in ? word_in : ~held[13:0];
		pin[14] = flag_oe_in ? flag_in : ~held[14];
	end
	always @(posedge clk_in) begin
		held <= pin;
		if (strobe_in) begin
			got_out <= pin;
		end
	end
endmodule

// ===== dv/tb.sv
// Self-checking bench for the converter format and power block
`timescale 1ns/1ps
module tb;
	import afp_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic sclk = 1'b0;
	logic [1:0] mode = 2'h0;
	logic pd = 1'b0;
	logic dis = 1'b0;
	logic signed [15:0] ain = 16'sh0;
	logic [13:0] word;
	logic word_oe, flag, flag_oe, strobe, invalid, locked, duty_bad;
	afp_mode_s mode_q;
	afp_pwr_e pwr;
	logic [14:0] got;
	logic iclk;
	int iclk_run = 0;
	int iclk_len = 0;
	int num_errors = 0;
	int tests_run = 0;
	always #5 clk = ~clk;
	afp_top #(.SLEEP_CYC(50)) dut_u (.ref_clk_in(clk), .reset_in(rst), .sample_clk_in(sclk),
		.mode_level_in(mode), .power_down_select_in(pd), .out_disable_in(dis),
		.analog_value_in(ain), .sample_word_out(word), .sample_word_oe_out(word_oe),
		.range_exceeded_flag_out(flag), .range_exceeded_flag_oe_out(flag_oe),
		.sample_strobe_out(strobe), .data_invalid_out(invalid), .stab_locked_out(locked),
		.internal_clk_out(iclk), .duty_fault_out(duty_bad), .mode_out(mode_q),
		.power_state_out(pwr));
	afp_sink sink_u (.clk_in(clk), .word_in(word), .word_oe_in(word_oe), .flag_in(flag),
		.flag_oe_in(flag_oe), .strobe_in(strobe), .got_out(got));
	// High time of the last complete internal clock pulse
	always @(posedge clk) begin
		if (iclk) begin
			iclk_run <= iclk_run + 1;
		end else begin
			iclk_run <= 0;
			if (iclk_run != 0) begin
				iclk_len <= iclk_run;
			end
		end
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Period of hi plus lo ref cycles, eight or four here, keeps the rate well above the floor
	task automatic pulse(input logic signed [15:0] v, input int hi, input int lo);
		ain <= v;
		sclk <= 1'b1;
		step(hi);
		sclk <= 1'b0;
		step(lo);
	endtask
	function automatic logic [15:0] fmt(input int v, input logic twos);
		int c;
		logic [13:0] w;
		c = (v > 8191) ? 8191 : ((v < -8192) ? -8192 : v);
		w = 14'(c + 8192);
		w[13] = w[13] ^ twos;
		return {1'b0, (v > 8191) || (v < -8192), w};
	endfunction
	task automatic give_verdict();
		if (num_errors == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		int vals[5] = '{-9000, -8192, 0, 8191, 9000};
		step(20);
		rst <= 1'b0;
		step(5);
		for (int m = 0; m < 4; m++) begin
			mode <= 2'(m);
			step(6);
			chk("mode", {14'h0, mode_q}, {14'h0, m[1], m[1] ^ m[0]});
			foreach (vals[i]) begin
				pulse(16'(vals[i]), 4, 4);
				chk("word", {1'b0, got}, fmt(vals[i], m[1]));
			end
		end
		pulse(16'sh0, 6, 2);
		pulse(16'sh0, 6, 2);
		chk("duty", {15'h0, duty_bad}, 16'h1);
		mode <= 2'h1;
		repeat (95) pulse(16'sh0, 4, 4);
		chk("lock", {14'h0, locked, invalid}, 16'h1);
		repeat (10) pulse(16'sh0, 4, 4);
		chk("lock", {14'h0, locked, invalid}, 16'h2);
		// Skewed input duty must still give a half-period internal high
		pulse(16'sh0, 6, 2);
		pulse(16'sh0, 6, 2);
		chk("iclk", 16'(iclk_len), 16'h4);
		step(120);
		chk("stop", {15'h0, locked}, 16'h0);
		mode <= 2'h0;
		pulse(16'sh100, 2, 2);
		pulse(16'sh100, 2, 2);
		step(4);
		chk("rate", {15'h0, invalid}, 16'h0);
		chk("word", {1'b0, got}, fmt(256, 1'b0));
		// Disable only toggled while the sample clock idles
		dis <= 1'b1;
		step(6);
		chk("float", {14'h0, word_oe, flag_oe}, 16'h0);
		dis <= 1'b0;
		pd <= 1'b1;
		step(6);
		chk("nap", {10'h0, pwr, word_oe, flag_oe, invalid}, {10'h0, AFP_NAP, 3'h1});
		pd <= 1'b0;
		repeat (95) pulse(16'sh0, 4, 4);
		chk("naprcv", {13'h0, pwr}, {13'h0, AFP_NAP_RCV});
		repeat (10) pulse(16'sh0, 4, 4);
		chk("run", {10'h0, pwr, word_oe, flag_oe, invalid}, {10'h0, AFP_RUN, 3'h6});
		dis <= 1'b1;
		pd <= 1'b1;
		step(6);
		chk("sleep", {10'h0, pwr, word_oe, flag_oe, invalid}, {10'h0, AFP_SLEEP, 3'h1});
		pd <= 1'b0;
		dis <= 1'b0;
		step(30);
		chk("slprcv", {13'h0, pwr}, {13'h0, AFP_SLEEP_RCV});
		step(40);
		chk("run", {10'h0, pwr, word_oe, flag_oe, invalid}, {10'h0, AFP_RUN, 3'h6});
		give_verdict();
	end
	initial begin
		step(10000);
		num_errors++;
		give_verdict();
	end
endmodule
